// ### rtl/bdp_defs.svh
// Constants for the direct-PWM brushless driver block.
// Assumes a single 125 MHz clock; included by bare name from the rtl files.
`ifndef BDP_DEFS_SVH
`define BDP_DEFS_SVH
`define BDP_CLK_HZ 125000000
`define BDP_PWM_MAX_HZ 40000
// Least period rounds up to whole cycles.
`define BDP_PWM_MIN_CYC ((`BDP_CLK_HZ + `BDP_PWM_MAX_HZ - 1) / `BDP_PWM_MAX_HZ)
`define BDP_DUTY_W 8
`define BDP_DUTY_FULL 8'hFF
`define BDP_PH_A 0
`define BDP_PH_B 1
`define BDP_PH_C 2
`endif

// ### rtl/bdp_pkg.sv
// Types shared by the driver block.
// Assumes bdp_defs.svh supplies the numbers.
package bdp_pkg;
   typedef enum logic [1:0] {
      BDP_RUN = 2'b00,
      BDP_HALT = 2'b01,
      BDP_LIMIT = 2'b10
   } bdp_mode_e;
   typedef struct packed {
      logic [2:0] src;
      logic [2:0] snk;
   } bdp_drive_s;
endpackage

// ### rtl/bdp_if.sv
// PWM carrier between the top and the PWM timebase.
// Assumes one clock domain.
`timescale 1ns/10ps
`include "bdp_defs.svh"
interface bdp_if;
   logic [`BDP_DUTY_W-1:0] duty;
   logic pwm_on;
   logic period_start;
   modport top (output duty, input pwm_on, input period_start);
   modport gen (input duty, output pwm_on, output period_start);
endinterface

// ### rtl/bdp_pwm_gen.sv
// PWM timebase: a cycle counter and an 8-bit duty compare.
// Assumes duty arrives on the interface, synchronous to ref_clk_in.
`timescale 1ns/10ps
`include "bdp_defs.svh"
module bdp_pwm_gen #(
   parameter int PERIOD_CYC = 3200
) (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Carrier.
   bdp_if.gen pw
);
   typedef struct packed {
      logic [11:0] cnt;
      logic [`BDP_DUTY_W-1:0] duty;
      logic on;
      logic start;
   } bdp_pwm_st_s;
   bdp_pwm_st_s st_r;
   bdp_pwm_st_s st_nxt;
   localparam logic [11:0] LAST = 12'(PERIOD_CYC - 1);
   // Period of at least the least cycle count keeps frequency bounded.
   initial if (PERIOD_CYC < `BDP_PWM_MIN_CYC) $error("PWM period too short");
   // Duty is latched at each period start so a mid-period change cannot glitch.
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.start = (st_r.cnt == LAST);
      st_nxt.cnt = (st_r.cnt == LAST) ? 12'h000 : 12'(st_r.cnt + 12'h001);
      if (st_r.cnt == LAST)
      begin
         st_nxt.duty = pw.duty;
      end
      // Full code gives full conduction, zero gives none.
      st_nxt.on = (st_r.duty == `BDP_DUTY_FULL) ||
                  ({st_r.cnt, 8'h00} < (20'(st_r.duty) * 20'(PERIOD_CYC)));
   end
   // State register.
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
   assign pw.pwm_on = st_r.on;
   assign pw.period_start = st_r.start;
endmodule // bdp_pwm_gen

// ### rtl/bdp_driver.sv
// Top of the direct-PWM three-phase brushless driver.
// Assumes hall, protection and control inputs are synchronous to ref_clk_in.
`timescale 1ns/10ps
`include "bdp_defs.svh"
module bdp_driver #(
   parameter int PERIOD_CYC = 3200
) (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Hall sensors.
   input wire logic hall_phase_a_in,
   input wire logic hall_phase_b_in,
   input wire logic hall_phase_c_in,
   // Control.
   input wire logic [7:0] speed_level_in,
   input wire logic halt_in,
   input wire logic reverse_in,
   // Protection.
   input wire logic undervoltage_in,
   input wire logic overtemperature_in,
   input wire logic current_limit_in,
   // Bridge drives, index 0 is phase a.
   output logic [2:0] source_on_out,
   output logic [2:0] sink_on_out,
   // Speed pulses and status.
   output logic speed_pulse_single_out,
   output logic speed_pulse_triple_out,
   output logic source_disabled_out
);
   typedef struct packed {
      bdp_pkg::bdp_drive_s drv;
      logic [2:0] hall;
      logic triple;
      logic primed;
      logic dis;
      logic lim;
      bdp_pkg::bdp_mode_e mode;
   } bdp_top_st_s;
   bdp_top_st_s st_r;
   bdp_top_st_s st_nxt;
   bdp_if pw ();
   bdp_pwm_gen #(.PERIOD_CYC(PERIOD_CYC)) u_pwm (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .pw(pw)
   );
   assign pw.duty = speed_level_in;
   // Forward commutation table; reverse swaps source and sink.
   function automatic bdp_pkg::bdp_drive_s commutate(input logic [2:0] h, input logic rev);
      bdp_pkg::bdp_drive_s d;
      d = '0;
      case (h) // h = {c, b, a}
         3'h1: d = '{src: 3'h2, snk: 3'h1};
         3'h3: d = '{src: 3'h4, snk: 3'h1};
         3'h2: d = '{src: 3'h4, snk: 3'h2};
         3'h6: d = '{src: 3'h1, snk: 3'h2};
         3'h4: d = '{src: 3'h1, snk: 3'h4};
         3'h5: d = '{src: 3'h2, snk: 3'h4};
         default: d = '0; // Invalid hall code: bridge idle.
      endcase
      if (rev)
      begin
         commutate = '{src: d.snk, snk: d.src};
      end
      else
      begin
         commutate = d;
      end
   endfunction
   logic [2:0] hall_now;
   assign hall_now = {hall_phase_c_in, hall_phase_b_in, hall_phase_a_in};
   // Commutation, protection gating and speed pulse shaping.
   always_comb
   begin
      bdp_pkg::bdp_drive_s d;
      d = commutate(hall_now, reverse_in);
      st_nxt = st_r;
      st_nxt.hall = hall_now;
      // One shared disable: undervoltage, overtemperature and halt land here; current limit does not.
      st_nxt.dis = undervoltage_in | overtemperature_in | halt_in;
      st_nxt.lim = current_limit_in;
      if (halt_in)
      begin
         st_nxt.mode = bdp_pkg::BDP_HALT;
      end
      else if (current_limit_in)
      begin
         st_nxt.mode = bdp_pkg::BDP_LIMIT;
      end
      else
      begin
         st_nxt.mode = bdp_pkg::BDP_RUN;
      end
      // Chopping is applied to source only; sink holds, giving short brake.
      st_nxt.drv.snk = d.snk;
      if (st_nxt.dis || current_limit_in || !pw.pwm_on)
      begin
         st_nxt.drv.src = 3'h0;
      end
      else
      begin
         st_nxt.drv.src = d.src;
      end
      // The hall copy after reset is a guess, so the first sample only primes it.
      st_nxt.primed = 1'b1;
      // Any hall edge toggles the triple pulse: six edges, three periods.
      if (st_r.primed && (hall_now != st_r.hall))
      begin
         st_nxt.triple = ~st_r.triple;
      end
   end
   // State register; direction is assumed steady while running.
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         st_r <= '{drv: '0, hall: 3'h0, triple: 1'b0, primed: 1'b0, dis: 1'b1, lim: 1'b0,
                   mode: bdp_pkg::BDP_HALT};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end
   assign source_on_out = st_r.drv.src;
   assign sink_on_out = st_r.drv.snk;
   assign speed_pulse_single_out = st_r.hall[`BDP_PH_A];
   assign speed_pulse_triple_out = st_r.triple;
   assign source_disabled_out = st_r.dis;

   // Checks.
   property p_cut_off;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (undervoltage_in | overtemperature_in | halt_in) |=> (source_on_out == 3'h0);
   endproperty
   a_cut_off: assert property (p_cut_off) else $error("source on during cutoff");
   property p_limit;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      current_limit_in |=> (source_on_out == 3'h0);
   endproperty
   a_limit: assert property (p_limit) else $error("source on during limit");
   property p_brake;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (current_limit_in && $stable(hall_now) && $stable(reverse_in))
         |=> (sink_on_out == $past(sink_on_out) || $past(sink_on_out) == 3'h0);
   endproperty
   a_brake: assert property (p_brake) else $error("sink dropped in limit");
   property p_onehot;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      $onehot0(source_on_out) && $onehot0(sink_on_out) && !(|(source_on_out & sink_on_out));
   endproperty
   a_onehot: assert property (p_onehot) else $error("bad phase selection");
   property p_single;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      1'b1 |=> (speed_pulse_single_out == $past(hall_phase_a_in));
   endproperty
   a_single: assert property (p_single) else $error("single pulse mismatch");
   property p_triple;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (st_r.primed && (hall_now != st_r.hall))
         |=> (speed_pulse_triple_out != $past(speed_pulse_triple_out));
   endproperty
   a_triple: assert property (p_triple) else $error("triple pulse missed");
   property p_dis;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      !halt_in ##1 !halt_in |-> (source_disabled_out == $past(undervoltage_in | overtemperature_in));
   endproperty
   a_dis: assert property (p_dis) else $error("disable mismatch");
   property p_src_sink;
      @(posedge ref_clk_in) disable iff (!rst_n_in)
      (|source_on_out) |-> (|sink_on_out) && !source_disabled_out;
   endproperty
   a_src_sink: assert property (p_src_sink) else $error("source without sink");
   c_run: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in) |source_on_out);
   c_limit: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      st_r.mode == bdp_pkg::BDP_LIMIT && |sink_on_out);
   c_triple: cover property (@(posedge ref_clk_in) disable iff (!rst_n_in)
      $rose(speed_pulse_triple_out));
endmodule // bdp_driver

// ### dv/bdp_motor_model.sv
// Motor and hall sensor model: the rotor walks the six hall codes.
// Assumes the bench pulses step_in for one cycle per electrical step.
`timescale 1ns/10ps
module bdp_motor_model (
   // Clock and reset.
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Rotor control.
   input wire logic step_in,
   input wire logic reverse_in,
   input wire logic fault_in,
   // Hall levels, bit 0 is phase a.
   output logic [2:0] hall_out
);
   // Forward order of hall codes {c,b,a}; reverse walks it backwards.
   localparam logic [17:0] SEQ = {3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
   logic [2:0] pos_r;
   // The rotor position moves one step per pulse, wrapping at six.
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         pos_r <= 3'h0;
      else if (step_in && reverse_in)
         pos_r <= (pos_r == 3'h0) ? 3'h5 : pos_r - 3'h1;
      else if (step_in)
         pos_r <= (pos_r == 3'h5) ? 3'h0 : pos_r + 3'h1;
   end
   // A broken sensor cable reads all low, a code the driver must refuse.
   assign hall_out = fault_in ? 3'h0 : SEQ[pos_r*3 +: 3];
endmodule // bdp_motor_model

// ### dv/bdp_driver_tb_top.sv
// Directed bench for the direct-PWM driver with a motor model.
// Assumes the design files and the motor model are compiled first.
`timescale 1ns/10ps
module bdp_driver_tb_top;
   localparam int PER = 3200;
   localparam int W = 4800;
   localparam logic [23:0] SRC_T = {3'h0, 3'h1, 3'h2, 3'h1, 3'h4, 3'h4, 3'h2, 3'h0};
   localparam logic [23:0] SNK_T = {3'h0, 3'h2, 3'h4, 3'h4, 3'h1, 3'h2, 3'h1, 3'h0};
   logic clk, rst_n, halt, rev, step, fault, t0, was, single, triple, dis;
   logic [2:0] prot, hall, src, snk;
   logic [7:0] speed;
   int errors, checked, cnt, rises;
   bdp_driver #(.PERIOD_CYC(PER)) bdp_driver_i (.ref_clk_in(clk), .rst_n_in(rst_n),
      .hall_phase_a_in(hall[0]), .hall_phase_b_in(hall[1]), .hall_phase_c_in(hall[2]),
      .speed_level_in(speed), .halt_in(halt), .reverse_in(rev),
      .undervoltage_in(prot[0]), .overtemperature_in(prot[1]), .current_limit_in(prot[2]),
      .source_on_out(src), .sink_on_out(snk), .speed_pulse_single_out(single),
      .speed_pulse_triple_out(triple), .source_disabled_out(dis));
   bdp_motor_model bdp_motor_model_i (.ref_clk_in(clk), .rst_n_in(rst_n), .step_in(step),
      .reverse_in(rev), .fault_in(fault), .hall_out(hall));
   // Expected drive: reverse swaps the source and sink columns.
   function automatic logic [2:0] pick(input logic want_src);
      return (want_src ^ rev) ? SRC_T[hall*3 +: 3] : SNK_T[hall*3 +: 3];
   endfunction
   task automatic chk(input string nm, input logic [2:0] e, input logic [2:0] g);
      checked++;
      if (g !== e)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Inputs always move one nanosecond after the edge, never on it.
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Wait past one period so the new level is latched, then count on-cycles.
   task automatic duty_run(input logic [7:0] lvl);
      speed = lvl;
      tick(PER + 50);
      cnt = 0;
      rises = 0;
      was = (src !== 3'h0);
      repeat (W)
      begin
         tick(1);
         if (src !== 3'h0 && !was)
            rises++;
         was = (src !== 3'h0);
         if (was)
            cnt++;
      end
   endtask
   task automatic final_report();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // The whole run is about 28000 cycles; twice that means a hang.
   initial
   begin
      repeat (60000) @(posedge clk);
      errors++;
      $display("MISMATCH watchdog expected finish seen hang");
      final_report();
   end
   initial
   begin
      rst_n = 1'b0;
      halt = 1'b1;
      rev = 1'b0;
      step = 1'b0;
      fault = 1'b0;
      prot = 3'h0;
      speed = 8'hFF;
      tick(3);
      chk("reset drive", 3'h0, src | snk);
      chk("reset pulses", 3'h4, {dis, single, triple});
      rst_n = 1'b1;
      tick(PER + 50);
      chk("halt source", 3'h0, src);
      chk("halt flag", 3'h1, {2'h0, dis});
      $display("test reset and halt done");
      for (int d = 0; d < 2; d++)
      begin
         halt = 1'b1;
         tick(1);
         rev = d[0];
         tick(1);
         halt = 1'b0;
         for (int s = 0; s < 6; s++)
         begin
            t0 = triple;
            step = 1'b1;
            tick(1);
            step = 1'b0;
            tick(3);
            chk("sink", pick(1'b0), snk);
            chk("source", pick(1'b1), src);
            chk("single", {2'h0, hall[0]}, {2'h0, single});
            chk("triple", {2'h0, ~t0}, {2'h0, triple});
         end
         $display("test direction %0d done", d);
      end
      for (int k = 0; k < 3; k++)
      begin
         prot = 3'h1 << k;
         tick(2);
         chk("cut source", 3'h0, src);
         chk("brake sink", pick(1'b0), snk);
         chk("disable", {2'h0, k != 2}, {2'h0, dis});
         prot = 3'h0;
         tick(3);
         chk("resume", pick(1'b1), src);
      end
      fault = 1'b1;
      tick(3);
      chk("bad hall", 3'h0, src | snk);
      fault = 1'b0;
      $display("test protection done");
      duty_run(8'h00);
      chk("duty zero", 3'h0, {2'h0, cnt != 0});
      duty_run(8'h80);
      chk("duty mid", 3'h1, {2'h0, cnt > 0 && cnt < W});
      chk("pwm rate", 3'h1, {2'h0, rises >= 1 && rises <= 2});
      duty_run(8'hFF);
      chk("duty full", 3'h1, {2'h0, cnt == W});
      $display("test duty done");
      final_report();
   end
endmodule // bdp_driver_tb_top
